//--- tb/adc_scan_sequencer_asserts.sv
// checker for the scan sequencer: bus handshake, front-end selection, sample codes
// assumes it is bound to adc_scan_sequencer and sees only its ports
`timescale 1ns/1ps
module adc_scan_sequencer_asserts
  import adc_scan_pkg::*;
#(
  parameter int unsigned PACE_MIN_CYCLES = 20
)
(
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                read,
  input wire logic                write,
  input wire logic                waitrequest,
  input wire logic                pacerPinOe,
  input wire logic                pacerPinOut,
  input wire logic [2:0]          muxChannel,
  input wire logic [2:0]          rangeSel,
  input wire logic [4:0]          gainFactor,
  input wire logic                diffMode,
  input wire logic                convStart,
  input wire logic                convDone,
  input wire logic [13:0]         convRaw,
  input wire adc_scan_pkg::code_t sampleData,
  input wire logic                sampleValid
);
  localparam logic [4:0] GAIN [8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0a, 5'h10, 5'h14};
  logic [5:0]  selPrev_q;
  logic [9:0]  since_q;
  logic [13:0] rawPrev_q;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ------
  // cycles since the front-end selection last moved
  // ------
  always_ff @(posedge sys_clk)
  begin
    selPrev_q <= {muxChannel, rangeSel};
    rawPrev_q <= convRaw;
    if (rst || selPrev_q != {muxChannel, rangeSel})
      since_q <= 10'h000;
    else if (since_q != 10'h3ff)
      since_q <= since_q + 10'h001;
  end
  AST_PIN_OUT_AFTER_RESET: assert property ($fell(rst) |-> pacerPinOe)
    else $error("pacer pin not driven after reset");
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus wait longer than one cycle");
  AST_NO_WAIT_IDLE: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised without request");
  // settle margin of a few cycles below the nominal figure
  AST_SETTLE_BEFORE_CONV: assert property (convStart |-> since_q >= 10'h1f0)
    else $error("conversion started before selection settled");
  AST_SEL_HOLD: assert property (convStart |=> ($stable(muxChannel) && $stable(rangeSel)) [*3])
    else $error("selection moved during conversion");
  AST_SAMPLE_AFTER_DONE: assert property (sampleValid |-> $past(convDone))
    else $error("sample without converter answer");
  AST_SE_SPAN: assert property (sampleValid && !diffMode |-> sampleData <= 12'h7ff)
    else $error("single-ended code above 11 bits");
  AST_SE_GAIN: assert property (convStart && !diffMode |-> rangeSel == 3'h1 && gainFactor == 5'h02)
    else $error("single-ended gain not two");
  AST_DIFF_GAIN: assert property (convStart && diffMode |-> gainFactor == GAIN[rangeSel])
    else $error("differential gain decode wrong");
  AST_DIFF_PAIRS: assert property (convStart && diffMode |-> !muxChannel[2])
    else $error("differential channel beyond four pairs");
  AST_OVER_SAT: assert property (sampleValid && diffMode && !rawPrev_q[13] && rawPrev_q[12:11] != 2'h0
    |-> sampleData == 12'hfff)
    else $error("over-range not saturated");
  cover property (sampleValid && diffMode);
  cover property (sampleValid && !diffMode);
  cover property (pacerPinOe && $rose(pacerPinOut));
  cover property (!pacerPinOe && sampleValid);
endmodule : adc_scan_sequencer_asserts

bind adc_scan_sequencer adc_scan_sequencer_asserts #(.PACE_MIN_CYCLES(PACE_MIN_CYCLES)) chk (
  .sys_clk(sys_clk), .rst(rst), .read(read), .write(write), .waitrequest(waitrequest),
  .pacerPinOe(pacerPinOe), .pacerPinOut(pacerPinOut), .muxChannel(muxChannel), .rangeSel(rangeSel),
  .gainFactor(gainFactor), .diffMode(diffMode), .convStart(convStart), .convDone(convDone),
  .convRaw(convRaw), .sampleData(sampleData), .sampleValid(sampleValid));

//--- tb/adc_scan_sequencer_bench.sv
// self-checking bench for the scan sequencer
// assumes the converter model answers every conversion start
`timescale 1ns/1ps
`include "adc_scan_regs.svh"
`define CHK(name, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("[ERR] %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module adc_scan_sequencer_bench;
  import adc_scan_pkg::*;
  // ------
  // signals
  // ------
  logic        sys_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, extPace = 1'b0, trig = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata, rdata;
  logic        waitrequest, pacerPinOut, pacerPinOe, pinWire, seenPace = 1'b0;
  logic [2:0]  muxChannel, rangeSel, sampleChannel;
  logic [4:0]  gainFactor;
  logic        diffMode, convStart, convDone, sampleValid, slow = 1'b0;
  logic [13:0] convRaw, rawVal = 14'h0;
  code_t       sampleData;
  code_t       sData [8];
  logic [2:0]  sCh [8];
  int          nSamp = 0, fail_count = 0, compares = 0;
  assign pinWire = pacerPinOe ? pacerPinOut : extPace;
  adc_scan_sequencer #(.PACE_MIN_CYCLES(20)) dut (
    .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .pacerPinIn(pinWire), .pacerPinOut(pacerPinOut), .pacerPinOe(pacerPinOe), .edgeTriggerPin(trig),
    .muxChannel(muxChannel), .rangeSel(rangeSel), .gainFactor(gainFactor), .diffMode(diffMode),
    .convStart(convStart), .convDone(convDone), .convRaw(convRaw), .sampleData(sampleData),
    .sampleChannel(sampleChannel), .sampleValid(sampleValid));
  conv_front_model fe (.sys_clk(sys_clk), .rst(rst), .slow(slow), .rawVal(rawVal),
    .convStart(convStart), .convDone(convDone), .convRaw(convRaw));
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (pacerPinOe === 1'b1 && pacerPinOut === 1'b1)
      seenPace <= 1'b1;
    if (sampleValid === 1'b1)
    begin
      sData[nSamp % 8] <= sampleData;
      sCh[nSamp % 8]   <= sampleChannel;
      nSamp            <= nSamp + 1;
    end
  end
  // ------
  // shared tasks
  // ------
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // entered just after a rising edge; request held until wait seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge sys_clk);
    end
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0)
    begin
      fail_count++;
      summarize();
    end
    @(posedge sys_clk);
  endtask : bus
  task automatic waitS(input int want);
    int n = 0;
    while (nSamp < want && n < 6000)
    begin
      n++;
      @(posedge sys_clk);
    end
    `CHK("sample count", want, nSamp)
    if (n == 6000)
      summarize();
    repeat (8) @(posedge sys_clk);
  endtask : waitS
  task automatic setup(input logic [3:0] last, input logic [15:0] cnt);
    bus(1'b1, `ADDR_QLAST, {28'h0, last});
    bus(1'b1, `ADDR_COUNT, {16'h0, cnt});
    bus(1'b1, `ADDR_PACE, 32'h14);
  endtask : setup
  // one link-clock period, then the pin stands still: pulses stay just below 50 kHz
  task automatic pulse();
    extPace <= 1'b1;
    repeat (20) @(posedge sys_clk);
    extPace <= 1'b0;
    repeat (4990) @(posedge sys_clk);
  endtask : pulse
  // ------
  // scenarios
  // ------
  task automatic scnReset();
    `CHK("pin drive after reset", 1'b1, pacerPinOe)
    bus(1'b1, 8'h20, 32'hffff_ffff);
    bus(1'b0, 8'h20, 32'h0);
    `CHK("unmapped read", 32'h0, rdata)
    bus(1'b0, `ADDR_STATUS, 32'h0);
    `CHK("idle status", 32'h0, rdata)
  endtask : scnReset
  task automatic scnQueue();
    logic [2:0] expCh [5] = '{3'h1, 3'h3, 3'h2, 3'h1, 3'h3};
    bus(1'b1, 8'h7c, 32'h2d);
    bus(1'b0, 8'h7c, 32'h0);
    `CHK("last queue slot", 32'h2d, rdata)
    bus(1'b1, 8'h40, 32'h01);
    bus(1'b1, 8'h44, 32'h3b);
    bus(1'b1, 8'h48, 32'h22);
    setup(4'h2, 16'h5);
    rawVal <= 14'h0bb8;
    slow <= 1'b1;
    nSamp = 0;
    bus(1'b1, `ADDR_CTRL, 32'hc1);
    waitS(5);
    for (int i = 0; i < 5; i++)
    begin
      `CHK("channel order", expCh[i], sCh[i])
      `CHK("saturated code", 12'hfff, sData[i])
    end
    repeat (800) @(posedge sys_clk);
    `CHK("no extra samples", 5, nSamp)
    bus(1'b0, `ADDR_STATUS, 32'h0);
    `CHK("done count and busy", 17'h0000a, {rdata[31:16], rdata[0]})
    `CHK("pacer on pin", 1'b1, seenPace)
    slow <= 1'b0;
  endtask : scnQueue
  task automatic scnSingle();
    logic [13:0] raw [2] = '{14'h3f9c, 14'h1388};
    code_t       exp [2] = '{12'h3ce, 12'h7ff};
    bus(1'b1, 8'h40, 32'h2e);
    setup(4'h0, 16'h1);
    for (int i = 0; i < 2; i++)
    begin
      rawVal <= raw[i];
      nSamp = 0;
      bus(1'b1, `ADDR_CTRL, 32'h01);
      waitS(1);
      `CHK("single-ended code", exp[i], sData[0])
      `CHK("single-ended channel", 3'h6, sCh[0])
      `CHK("fixed gain", 8'h22, {rangeSel, gainFactor})
    end
  endtask : scnSingle
  task automatic scnExt(input logic gated);
    setup(4'h0, 16'h3);
    nSamp = 0;
    bus(1'b1, `ADDR_CTRL, {24'h0, 1'b0, gated, 6'h25});
    repeat (700) @(posedge sys_clk);
    `CHK("pin released", 1'b0, pacerPinOe)
    repeat (3) pulse();
    `CHK("paced samples", gated ? 3 : 2, nSamp)
    bus(1'b0, `ADDR_STATUS, 32'h0);
    `CHK("busy after pulses", ~gated, rdata[0])
    bus(1'b1, `ADDR_CTRL, 32'h02);
    repeat (4) @(posedge sys_clk);
    `CHK("pin drives again", 1'b1, pacerPinOe)
  endtask : scnExt
  task automatic scnTrig(input logic fall);
    trig <= !fall;
    setup(4'h0, 16'h1);
    nSamp = 0;
    bus(1'b1, `ADDR_CTRL, {27'h0, fall, 4'h9});
    trig <= fall;
    repeat (1000) @(posedge sys_clk);
    `CHK("wrong edge ignored", 0, nSamp)
    trig <= !fall;
    waitS(1);
  endtask : scnTrig
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    scnReset();
    scnQueue();
    scnSingle();
    scnExt(1'b1);
    scnExt(1'b0);
    scnTrig(1'b1);
    scnTrig(1'b0);
    summarize();
  end
endmodule : adc_scan_sequencer_bench

//--- tb/conv_front_model.sv
// converter front end model: answers each conversion start with the bench's raw value
// assumes the bench picks the raw value and a prompt or slow answer
`timescale 1ns/1ps
module conv_front_model
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // bench control
  input  wire logic        slow,
  input  wire logic [13:0] rawVal,
  // converter handshake
  input  wire logic        convStart,
  output logic             convDone,
  output logic [13:0]      convRaw
);
  logic [5:0] pipe_q;
  always_ff @(posedge sys_clk)
  begin
    pipe_q <= rst ? 6'h00 : {pipe_q[4:0], convStart};
  end
  assign convDone = slow ? pipe_q[5] : pipe_q[1];
  // outside the answer cycle the value is inverted, so a stale capture shows
  assign convRaw = convDone ? rawVal : ~rawVal;
endmodule : conv_front_model

//--- verilog/adc_scan_pkg.sv
// types shared by the scan sequencer modules
// assumes adc_scan_regs.svh supplies the numeric constants
package adc_scan_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARM,
    ST_FETCH,
    ST_APPLY,
    ST_SETTLE,
    ST_WAITPACE,
    ST_CONV
  } scan_state_t;

  typedef logic [3:0]  qidx_t;
  typedef logic [5:0]  entry_t;
  typedef logic [11:0] code_t;

endpackage : adc_scan_pkg

//--- verilog/adc_scan_regs.svh
// register map, field positions, reset values and timing figures of the scan sequencer
// assumes a 250 MHz system clock and a byte-addressed 32-bit register bus
//
// Behaviour
// - each queue entry holds channel plus range
// - queue holds up to sixteen software-written entries
// - scan start fetches entry zero, applies, converts
// - after each conversion fetch, apply, convert next
// - after last configured entry wrap to zero
// - repeat until requested sample count, then stop
// - over-range input gives saturated full-scale code
// - pin as output drives internal pacer clock
// - pin as input: continuous or gated mode
// - continuous default: drop first external pulse
// - gated: convert on every pulse, first included
// - after reset the pacer pin is output
// - clock mode matters only for external pacing
// - hardware pacing sustains up to 50 kS/s
// - eight single-ended or four differential channels
// - differential results are full 12-bit codes
// - single-ended results span codes 0 to 2047
// - differential gains 1..20; single-ended fixed gain two
// - scan may start from external trigger pin
// - trigger edge selectable rising or falling
`ifndef ADC_SCAN_REGS_SVH
`define ADC_SCAN_REGS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ADDR_CTRL     8'h00
`define ADDR_QLAST    8'h04
`define ADDR_COUNT    8'h08
`define ADDR_PACE     8'h0c
`define ADDR_STATUS   8'h10
`define ADDR_DATA     8'h14
`define ADDR_QBASE_HI 2'h1
`define QAREA_MSB     7
`define QAREA_LSB     6
`define QIDX_MSB      5
`define QIDX_LSB      2

// ----------------------------------------------------------------------
// control bits
// ----------------------------------------------------------------------
`define CTRL_START    0
`define CTRL_STOP     1
`define CTRL_EXTPACE  2
`define CTRL_TRIGEN   3
`define CTRL_TRIGFALL 4
`define CTRL_SYNCIN   5
`define CTRL_GATED    6
`define CTRL_DIFF     7
`define CTRL_RST      8'h00

// ----------------------------------------------------------------------
// status and entry fields
// ----------------------------------------------------------------------
`define STAT_BUSY     0
`define STAT_NEW      1
`define STAT_IDX_LSB  8
`define STAT_CNT_LSB  16
`define ENT_CH_LSB    0
`define ENT_RG_LSB    3

// ----------------------------------------------------------------------
// conversion codes
// ----------------------------------------------------------------------
`define CODE_DIFF_MAX 15'sh0fff
`define CODE_SE_MAX   15'sh07ff
`define CODE_DIFF_MID 15'sh0800
`define CODE_SE_MID   15'sh0400
`define SE_RANGE      3'h1
`define DIFF_CH_MASK  3'h3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_NS        4
`define MAX_RATE_SPS  50000
`define PACE_MIN_NS   (1000000000 / `MAX_RATE_SPS)
`define SETTLE_NS     2000
`define SETTLE_CYC    16'((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define PACE_MIN_CYC  ((`PACE_MIN_NS + `CLK_NS - 1) / `CLK_NS)

`endif

//--- verilog/adc_scan_sequencer.sv
// scan sequencer: channel/range queue walk, pacing, trigger and register slave
// assumes an avalon-mm master on sys_clk and a converter front end on the same clock
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "adc_scan_regs.svh"
module adc_scan_sequencer
  import adc_scan_pkg::*;
#(
  parameter int unsigned PACE_MIN_CYCLES = `PACE_MIN_CYC
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // pacer pin, two-way
  input  wire logic        pacerPinIn,
  output logic             pacerPinOut,
  output logic             pacerPinOe,
  // external edge trigger
  input  wire logic        edgeTriggerPin,
  // converter front end
  output logic [2:0]       muxChannel,
  output logic [2:0]       rangeSel,
  output logic [4:0]       gainFactor,
  output logic             diffMode,
  output logic             convStart,
  input  wire logic        convDone,
  input  wire logic [13:0] convRaw,
  // sample stream
  output adc_scan_pkg::code_t sampleData,
  output logic [2:0]       sampleChannel,
  output logic             sampleValid
);
  import adc_scan_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // out-of-range input simply pins to the end code, nothing flags it
  function automatic code_t saturate(input logic [13:0] raw, input logic diff);
    logic signed [14:0] v;
    logic signed [14:0] top;
    v   = diff ? ($signed({raw[13], raw}) + `CODE_DIFF_MID)
               : ($signed({raw[13], raw[13], raw[13:1]}) + `CODE_SE_MID);
    top = diff ? `CODE_DIFF_MAX : `CODE_SE_MAX;
    if (v < 0)
    begin
      v = '0;
    end
    else if (v > top)
    begin
      v = top;
    end
    return code_t'(v[11:0]);
  endfunction : saturate

  function automatic logic [4:0] gain_of(input logic [2:0] rg);
    logic [4:0] g;
    case (rg)
      3'h0:    g = 5'h01;
      3'h1:    g = 5'h02;
      3'h2:    g = 5'h04;
      3'h3:    g = 5'h05;
      3'h4:    g = 5'h08;
      3'h5:    g = 5'h0a;
      3'h6:    g = 5'h10;
      default: g = 5'h14;
    endcase
    return g;
  endfunction : gain_of

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    qidx_t       qLast;
    logic [31:0] target;
    logic [31:0] paceDiv;
    scan_state_t st;
    qidx_t       idx;
    logic [31:0] done;
    logic [31:0] paceCnt;
    logic        pacerLvl;
    logic        pend;
    logic        firstSeen;
    logic [15:0] settle;
    logic [2:0]  chan;
    logic [2:0]  rng;
    code_t       data;
    logic [2:0]  dataChan;
    logic        dataNew;
    logic        sampleValid;
    logic        convStart;
    logic        ack;
    logic        qRead;
    logic [31:0] rdata;
  } seq_state_t;

  seq_state_t s_q, s_d;

  logic   syncLvl, syncRise, syncFall;
  logic   trigLvl, trigRise, trigFall;
  entry_t seqEntry, busEntry;
  logic   busReq, busDone, qArea, qWrite;
  logic [31:0] paceEff;
  logic   useExt, intTick, extTick, tick, trigHit;

  // ----------------------------------------------------------------------
  // pins and queue memory
  // ----------------------------------------------------------------------
  pin_sync u_pacer_sync
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (pacerPinIn),
    .level   (syncLvl),
    .rise    (syncRise),
    .fall    (syncFall)
  );

  pin_sync u_trig_sync
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (edgeTriggerPin),
    .level   (trigLvl),
    .rise    (trigRise),
    .fall    (trigFall)
  );

  queue_mem u_queue
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wrEn    (qWrite),
    .wrAddr  (address[`QIDX_MSB:`QIDX_LSB]),
    .wrData  (writedata[5:0]),
    .rdAddrA (s_q.idx),
    .rdDataA (seqEntry),
    .rdAddrB (address[`QIDX_MSB:`QIDX_LSB]),
    .rdDataB (busEntry)
  );

  // ----------------------------------------------------------------------
  // bus decode: every access answers on the second edge
  // ----------------------------------------------------------------------
  assign busReq  = (read | write) & ~s_q.ack;
  assign busDone = (read | write) & s_q.ack;
  assign qArea   = (address[`QAREA_MSB:`QAREA_LSB] == `ADDR_QBASE_HI);
  assign qWrite  = write & s_q.ack & qArea & byteenable[0];

  // a pacer faster than the converter allows is clamped, not refused
  assign paceEff = (s_q.paceDiv < PACE_MIN_CYCLES) ? PACE_MIN_CYCLES : s_q.paceDiv;
  assign useExt  = s_q.ctrl[`CTRL_EXTPACE];
  assign intTick = (s_q.paceCnt == '0);
  // external edges arrive at most at 50 kHz, so the sync stage never merges two
  assign extTick = syncRise & s_q.ctrl[`CTRL_SYNCIN];
  assign tick    = useExt ? extTick : intTick;
  assign trigHit = s_q.ctrl[`CTRL_TRIGFALL] ? trigFall : trigRise;

  always_comb
  begin
    s_d             = s_q;
    s_d.sampleValid = 1'b0;
    s_d.convStart   = 1'b0;
    s_d.ack         = busReq;

    // --------------------------------------------------------------------
    // register reads, captured one edge ahead of the answer
    // --------------------------------------------------------------------
    s_d.qRead = qArea;
    s_d.rdata = '0;
    case (address)
      `ADDR_CTRL:   s_d.rdata[7:0] = s_q.ctrl;
      `ADDR_QLAST:  s_d.rdata[3:0] = s_q.qLast;
      `ADDR_COUNT:  s_d.rdata      = s_q.target;
      `ADDR_PACE:   s_d.rdata      = s_q.paceDiv;
      `ADDR_STATUS:
      begin
        s_d.rdata[`STAT_BUSY]                  = (s_q.st != ST_IDLE);
        s_d.rdata[`STAT_NEW]                   = s_q.dataNew;
        s_d.rdata[`STAT_IDX_LSB +: 4]          = s_q.idx;
        s_d.rdata[`STAT_CNT_LSB +: 16]         = s_q.done[15:0];
      end
      `ADDR_DATA:   s_d.rdata[11:0] = s_q.data;
      default:      s_d.rdata = '0;
    endcase

    // --------------------------------------------------------------------
    // register writes, effective on the answering edge
    // --------------------------------------------------------------------
    if (write & s_q.ack)
    begin
      case (address)
        `ADDR_CTRL:
        begin
          if (byteenable[0])
          begin
            s_d.ctrl = writedata[7:0];
            s_d.ctrl[`CTRL_START] = 1'b0;
            s_d.ctrl[`CTRL_STOP]  = 1'b0;
          end
        end
        `ADDR_QLAST:
        begin
          if (byteenable[0])
          begin
            s_d.qLast = writedata[3:0];
          end
        end
        `ADDR_COUNT: s_d.target  = merge(s_q.target, writedata, byteenable);
        `ADDR_PACE:  s_d.paceDiv = merge(s_q.paceDiv, writedata, byteenable);
        default:     s_d.qLast   = s_q.qLast;
      endcase
    end
    if (read & s_q.ack & (address == `ADDR_DATA))
    begin
      s_d.dataNew = 1'b0;
    end

    // --------------------------------------------------------------------
    // internal pacer, also driven out on the pacer pin
    // --------------------------------------------------------------------
    if (s_q.st == ST_IDLE || s_q.st == ST_ARM || intTick)
    begin
      s_d.paceCnt = paceEff - 32'h1;
    end
    else
    begin
      s_d.paceCnt = s_q.paceCnt - 32'h1;
    end
    s_d.pacerLvl = (s_q.st != ST_IDLE) && (s_q.st != ST_ARM)
                   && (s_q.paceCnt >= (paceEff >> 1));

    // --------------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------------
    case (s_q.st)
      ST_IDLE:
      begin
        if (write & s_q.ack & (address == `ADDR_CTRL) & byteenable[0]
            & writedata[`CTRL_START] & (s_q.target != '0))
        begin
          s_d.idx       = '0;
          s_d.done      = '0;
          s_d.pend      = 1'b0;
          s_d.firstSeen = 1'b0;
          s_d.st        = writedata[`CTRL_TRIGEN] ? ST_ARM : ST_FETCH;
        end
      end
      ST_ARM:
      begin
        if (trigHit)
        begin
          s_d.st = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        s_d.st = ST_APPLY;
      end
      ST_APPLY:
      begin
        s_d.chan   = seqEntry[`ENT_CH_LSB +: 3];
        s_d.rng    = s_q.ctrl[`CTRL_DIFF] ? seqEntry[`ENT_RG_LSB +: 3] : `SE_RANGE;
        if (s_q.ctrl[`CTRL_DIFF])
        begin
          s_d.chan = seqEntry[`ENT_CH_LSB +: 3] & `DIFF_CH_MASK;
        end
        s_d.settle = `SETTLE_CYC - 16'h1;
        s_d.st     = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        if (s_q.settle == '0)
        begin
          s_d.st = ST_WAITPACE;
        end
        else
        begin
          s_d.settle = s_q.settle - 16'h1;
        end
      end
      ST_WAITPACE:
      begin
        if (s_q.pend)
        begin
          s_d.pend      = 1'b0;
          s_d.convStart = 1'b1;
          s_d.st        = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (convDone)
        begin
          s_d.data        = saturate(convRaw, s_q.ctrl[`CTRL_DIFF]);
          s_d.dataChan    = s_q.chan;
          s_d.dataNew     = 1'b1;
          s_d.sampleValid = 1'b1;
          s_d.done        = s_q.done + 32'h1;
          s_d.idx         = (s_q.idx == s_q.qLast) ? '0 : s_q.idx + 4'h1;
          s_d.st          = (s_q.done + 32'h1 == s_q.target) ? ST_IDLE : ST_FETCH;
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase

    // --------------------------------------------------------------------
    // pace ticks held for the sequencer; after it, so a tick on the consuming edge is kept
    // --------------------------------------------------------------------
    if (tick && s_q.st != ST_IDLE && s_q.st != ST_ARM)
    begin
      if (useExt && !s_q.ctrl[`CTRL_GATED] && !s_q.firstSeen)
      begin
        s_d.firstSeen = 1'b1;
      end
      else
      begin
        s_d.pend = 1'b1;
      end
    end

    if (write & s_q.ack & (address == `ADDR_CTRL) & byteenable[0] & writedata[`CTRL_STOP])
    begin
      s_d.st   = ST_IDLE;
      s_d.pend = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q      <= '0;
      s_q.ctrl <= `CTRL_RST;
      s_q.st   <= ST_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign waitrequest   = busReq;
  assign readdata      = s_q.qRead ? {26'h0, busEntry} : s_q.rdata;
  assign pacerPinOut   = s_q.pacerLvl;
  assign pacerPinOe    = ~s_q.ctrl[`CTRL_SYNCIN];
  assign muxChannel    = s_q.chan;
  assign rangeSel      = s_q.rng;
  assign gainFactor    = gain_of(s_q.rng);
  assign diffMode      = s_q.ctrl[`CTRL_DIFF];
  assign convStart     = s_q.convStart;
  assign sampleData    = s_q.data;
  assign sampleChannel = s_q.dataChan;
  assign sampleValid   = s_q.sampleValid;

endmodule : adc_scan_sequencer

//--- verilog/pin_sync.sv
// two-flop synchroniser with edge detection for a pin from outside the clock domain
// assumes the pin changes no faster than a few system clocks
`timescale 1ns/1ps
module pin_sync
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // pin and decoded edges
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_t;

  sync_state_t s_q, s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pinIn;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // only the second stage and its delayed copy are looked at
  assign level = s_q.sync;
  assign rise  = s_q.sync & ~s_q.prev;
  assign fall  = ~s_q.sync & s_q.prev;

endmodule : pin_sync

//--- verilog/queue_mem.sv
// sixteen-entry channel/range queue with one write port and two registered read ports
// assumes a single clock; port a serves the sequencer, port b the register bus
`timescale 1ns/1ps
module queue_mem
  import adc_scan_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // write port
  input  wire logic              wrEn,
  input  wire adc_scan_pkg::qidx_t  wrAddr,
  input  wire adc_scan_pkg::entry_t wrData,
  // read ports
  input  wire adc_scan_pkg::qidx_t  rdAddrA,
  output adc_scan_pkg::entry_t      rdDataA,
  input  wire adc_scan_pkg::qidx_t  rdAddrB,
  output adc_scan_pkg::entry_t      rdDataB
);
  import adc_scan_pkg::*;

  typedef struct packed {
    logic [15:0][5:0] mem;
    entry_t           rdA;
    entry_t           rdB;
  } mem_state_t;

  mem_state_t s_q, s_d;

  always_comb
  begin
    s_d     = s_q;
    s_d.rdA = s_q.mem[rdAddrA];
    s_d.rdB = s_q.mem[rdAddrB];
    if (wrEn)
    begin
      s_d.mem[wrAddr] = wrData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdDataA = s_q.rdA;
  assign rdDataB = s_q.rdB;

endmodule : queue_mem
